// >>> rtl/pulse_out_timer.sv
// Functional notes
// - Pulse when time matches pattern, masks ignored
// - Pattern is six BCD digits HHMMSS
// - Per-digit don't-care; all masked pulses each second
// - Default compares seconds to zero only
// - Width chosen from eight fixed values
// - One-second width every second stays high
// - Commit applies and saves pending settings
// - Offset below 1500ns trims oscillator only
// - Persistent large offset steps the time base
// - Re-enabling reference restarts fast acquisition
// - Jam counters, then 10ns steps below 10ns
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "pulse_out_defines.svh"

module pulse_out_timer
  import pulse_out_pkg::*;
#(
  parameter int SEC_CYCLES = `SEC_CYCLES,
  parameter logic [7:0][23:0] PW_CYCLES = {
    24'(SEC_CYCLES), `PW_CYC(`PW_500MS_US), `PW_CYC(`PW_200MS_US),
    `PW_CYC(`PW_100MS_US), `PW_CYC(`PW_10MS_US), `PW_CYC(`PW_1MS_US),
    `PW_CYC(`PW_100US_US), `PW_CYC(`PW_20US_US)}
)
(
  input wire logic clock_in, // 10 MHz clock
  input wire logic rst_in, // Synchronous reset
  input wire logic [7:0] addr_in, // Register byte address
  input wire logic [31:0] wr_data_in, // Write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  output logic [31:0] rd_data_out, // Read data, next cycle
  input wire logic ext_pps_in, // External 1pps pin
  output logic pulse_out, // Programmable pulse
  output logic sec_tick_out, // Internal seconds tick
  output logic [15:0] freq_trim_out, // Oscillator trim word
  output logic nv_save_out // Settings saved pulse
);

  // ----------------------------------------
  // Constants and declarations
  // ----------------------------------------
  localparam logic [26:0] SEC_UNITS = 27'(SEC_CYCLES * `UNITS_PER_CLK);
  localparam logic [26:0] HALF_UNITS = 27'(SEC_CYCLES * `UNITS_PER_CLK / 2);
  localparam logic [26:0] ADV = 27'(`UNITS_PER_CLK);
  localparam logic [27:0] TRIM_LIMIT = 28'(`TRIM_LIMIT_UNITS);
  localparam logic [1:0] PERSIST_LAST = 2'(`PERSIST_SECS - 1);

  logic pps_s1_r, pps_s2_r, pps_s3_r, ext_edge;
  logic ext_en_r, commit_wr, tod_wr;
  settings_s pending_r, active;
  bcd_time_t tod_r, tod_adv;
  logic [26:0] unit_cnt_r, unit_sum, adv, phase;
  logic jam, tick, tick_eff, match;
  logic [5:0] dig_hit;
  logic [23:0] care, pw_cnt_r, pw_cycles;
  logic pulse_r;
  acq_e acq_r;
  logic signed [27:0] offset_w, remain_r, last_off_r;
  logic [27:0] off_mag;
  logic meas_r;
  logic [1:0] persist_r;
  logic signed [15:0] trim_r;
  logic [8:0] sec_inc, min_inc, hr_inc;

  // Two-digit BCD increment with wrap at top, carry in bit 8
  function automatic logic [8:0] bcd2_inc(input logic [7:0] v,
                                          input logic [7:0] top);
    logic [8:0] r;
    r = 9'h000;
    if (v == top) begin
      r = 9'h100;
    end else if (v[3:0] == 4'h9) begin
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {1'b0, v + 8'h01};
    end
    return r;
  endfunction

  // Magnitude of a signed offset
  function automatic logic [27:0] mag(input logic signed [27:0] v);
    return v[27] ? 28'(-v) : 28'(v);
  endfunction

  // ----------------------------------------
  // Pin synchroniser and edge detect
  // ----------------------------------------
  // Two flops then an edge stage
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pps_s1_r <= 1'b0;
      pps_s2_r <= 1'b0;
      pps_s3_r <= 1'b0;
    end else begin
      pps_s1_r <= ext_pps_in;
      pps_s2_r <= pps_s1_r;
      pps_s3_r <= pps_s2_r;
    end
  end

  assign ext_edge = pps_s2_r & ~pps_s3_r;

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  assign commit_wr = wr_in && (addr_in == `REG_CTRL) &&
                     wr_data_in[`CTRL_COMMIT_BIT];
  assign tod_wr = wr_in && (addr_in == `REG_TOD);

  // Control and pending settings
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ext_en_r <= 1'b0;
      pending_r <= '{dont_care: `DEF_MASK, digits: `DEF_DIGITS,
                     width_sel: `DEF_WIDTH};
    end else if (wr_in) begin
      unique case (addr_in)
        `REG_CTRL: ext_en_r <= wr_data_in[`CTRL_EXT_EN_BIT];
        `REG_PEND_PAT: begin
          pending_r.digits <= wr_data_in[`PAT_DIGITS_MSB:0];
          pending_r.dont_care <=
            wr_data_in[`PAT_MASK_MSB:`PAT_MASK_LSB];
        end
        `REG_PEND_WIDTH: pending_r.width_sel <= wr_data_in[`WIDTH_MSB:0];
        default: ;
      endcase
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clock_in) begin
    if (rst_in || !rd_in) begin
      rd_data_out <= 32'h00000000;
    end else begin
      unique case (addr_in)
        `REG_CTRL: rd_data_out <= {31'h00000000, ext_en_r};
        `REG_PEND_PAT: rd_data_out <= {2'h0, pending_r.dont_care,
                                       pending_r.digits};
        `REG_PEND_WIDTH: rd_data_out <= {29'h00000000, pending_r.width_sel};
        `REG_ACT_PAT: rd_data_out <= {2'h0, active.dont_care,
                                      active.digits};
        `REG_ACT_WIDTH: rd_data_out <= {29'h00000000, active.width_sel};
        `REG_TOD: rd_data_out <= {8'h00, tod_r};
        `REG_STATUS: rd_data_out <= {29'h00000000, meas_r, acq_r};
        `REG_TRIM: rd_data_out <= {{16{trim_r[15]}}, trim_r};
        `REG_OFFSET: rd_data_out <= {{4{last_off_r[27]}}, last_off_r};
        default: rd_data_out <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // Committed settings store
  // ----------------------------------------
  setting_store u_store (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .wr_en_in(commit_wr),
    .wr_data_in(pending_r),
    .rd_data_out(active),
    .saved_out(nv_save_out)
  );

  // ----------------------------------------
  // Time base in 10 ns units
  // ----------------------------------------
  // Step advance by one unit while removing residual offset
  always_comb begin
    adv = ADV;
    if (acq_r == ACQ_FINE && remain_r > 28'sh0000000) begin
      adv = ADV - 27'h0000001;
    end else if (acq_r == ACQ_FINE && remain_r < 28'sh0000000) begin
      adv = ADV + 27'h0000001;
    end
  end

  assign unit_sum = unit_cnt_r + adv;
  assign jam = ext_en_r && (acq_r == ACQ_JAM) && ext_edge;
  // On jam, tick only if the internal second was nearly due
  assign tick = jam ? (unit_cnt_r >= HALF_UNITS) : (unit_sum >= SEC_UNITS);
  assign tick_eff = tick && !tod_wr;

  // Unit counter, reset to the reference on jam
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      unit_cnt_r <= 27'h0000000;
    end else if (jam) begin
      unit_cnt_r <= 27'h0000000;
    end else if (unit_sum >= SEC_UNITS) begin
      unit_cnt_r <= unit_sum - SEC_UNITS;
    end else begin
      unit_cnt_r <= unit_sum;
    end
  end

  // Phase one advance ahead, so an edge in the tick cycle reads zero
  assign phase = unit_cnt_r + ADV;

  // Signed offset of internal second from the reference edge
  always_comb begin
    if (phase >= HALF_UNITS) begin
      offset_w = $signed({1'b0, phase}) - $signed({1'b0, SEC_UNITS});
    end else begin
      offset_w = $signed({1'b0, phase});
    end
  end

  assign off_mag = mag(offset_w);

  // ----------------------------------------
  // Time of day
  // ----------------------------------------
  assign sec_inc = bcd2_inc(tod_r[7:0], 8'h59);
  assign min_inc = sec_inc[8] ? bcd2_inc(tod_r[15:8], 8'h59) :
                   {1'b0, tod_r[15:8]};
  assign hr_inc = min_inc[8] ? bcd2_inc(tod_r[23:16], 8'h23) :
                  {1'b0, tod_r[23:16]};
  assign tod_adv = {hr_inc[7:0], min_inc[7:0], sec_inc[7:0]};

  // Software set wins over the tick
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tod_r <= 24'h000000;
    end else if (tod_wr) begin
      tod_r <= wr_data_in[23:0];
    end else if (tick) begin
      tod_r <= tod_adv;
    end
  end

  // Seconds tick out
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sec_tick_out <= 1'b0;
    end else begin
      sec_tick_out <= tick_eff;
    end
  end

  // ----------------------------------------
  // Pattern compare and pulse
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_dig
      assign dig_hit[gi] = active.dont_care[gi] ||
        (tod_adv[4*gi+:4] == active.digits[4*gi+:4]);
      assign care[4*gi+:4] = {4{~active.dont_care[gi]}};
    end
  endgenerate

  assign match = &dig_hit;
  assign pw_cycles = PW_CYCLES[active.width_sel];

  // Start on matching tick, end after width or next tick for 1 s
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pulse_r <= 1'b0;
      pw_cnt_r <= 24'h000000;
    end else if (tick_eff && match) begin
      pulse_r <= 1'b1;
      pw_cnt_r <= 24'h000001;
    end else if (pulse_r) begin
      if (active.width_sel == `WIDTH_ONE_SEC) begin
        if (tick_eff) begin
          pulse_r <= 1'b0;
        end
      end else if (pw_cnt_r == pw_cycles) begin
        pulse_r <= 1'b0;
      end
      pw_cnt_r <= pw_cnt_r + 24'h000001;
    end
  end

  assign pulse_out = pulse_r;

  // ----------------------------------------
  // External reference acquisition
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      acq_r <= ACQ_OFF;
      remain_r <= 28'sh0000000;
      meas_r <= 1'b0;
      persist_r <= 2'h0;
      trim_r <= 16'sh0000;
      last_off_r <= 28'sh0000000;
    end else if (!ext_en_r) begin
      acq_r <= ACQ_OFF;
      meas_r <= 1'b0;
      persist_r <= 2'h0;
      remain_r <= 28'sh0000000;
    end else begin
      if (ext_edge) begin
        last_off_r <= offset_w;
      end
      unique case (acq_r)
        ACQ_OFF: acq_r <= ACQ_JAM;
        ACQ_JAM: begin
          if (ext_edge) begin
            acq_r <= ACQ_FINE;
            meas_r <= 1'b0;
          end
        end
        ACQ_FINE: begin
          if (ext_edge) begin
            remain_r <= offset_w;
            meas_r <= 1'b1;
          end else if (remain_r > 28'sh0000000) begin
            remain_r <= remain_r - 28'sh0000001;
          end else if (remain_r < 28'sh0000000) begin
            remain_r <= remain_r + 28'sh0000001;
          end else if (meas_r) begin
            acq_r <= ACQ_TRACK;
          end
        end
        ACQ_TRACK: begin
          if (ext_edge && off_mag < TRIM_LIMIT) begin
            persist_r <= 2'h0;
            if (offset_w > 28'sh0000000) begin
              trim_r <= trim_r - 16'sh0001;
            end else if (offset_w < 28'sh0000000) begin
              trim_r <= trim_r + 16'sh0001;
            end
          end else if (ext_edge && persist_r == PERSIST_LAST) begin
            persist_r <= 2'h0;
            acq_r <= ACQ_JAM;
          end else if (ext_edge) begin
            persist_r <= persist_r + 2'h1;
          end
        end
      endcase
    end
  end

  assign freq_trim_out = trim_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);

  property p_match_start;
    tick_eff && match |=> pulse_r && pw_cnt_r == 24'h000001;
  endproperty
  a_match_start: assert property (p_match_start)
    else $error("pulse did not start on matching tick");

  property p_rise_matches;
    $rose(pulse_r) |->
      ((tod_r ^ $past(active.digits)) & $past(care)) == 24'h000000;
  endproperty
  a_rise_matches: assert property (p_rise_matches)
    else $error("pulse rose on a non-matching time");

  property p_all_masked;
    (&active.dont_care) && tick_eff |=> pulse_r;
  endproperty
  a_all_masked: assert property (p_all_masked)
    else $error("fully masked pattern missed a second");

  property p_default;
    $past(rst_in) |-> active.dont_care == `DEF_MASK &&
      active.digits == `DEF_DIGITS && active.width_sel == `DEF_WIDTH;
  endproperty
  a_default: assert property (p_default)
    else $error("settings not at default after reset");

  property p_width_end;
    pulse_r && active.width_sel != `WIDTH_ONE_SEC &&
      pw_cnt_r == pw_cycles && !(tick_eff && match) |=> !pulse_r;
  endproperty
  a_width_end: assert property (p_width_end)
    else $error("pulse did not end at selected width");

  property p_one_sec_hold;
    pulse_r && active.width_sel == `WIDTH_ONE_SEC && !tick_eff |=> pulse_r;
  endproperty
  a_one_sec_hold: assert property (p_one_sec_hold)
    else $error("one second pulse dropped early");

  property p_commit;
    commit_wr |=> active == $past(pending_r) ##0 nv_save_out;
  endproperty
  a_commit: assert property (p_commit)
    else $error("commit did not apply pending settings");

  property p_no_commit;
    !commit_wr |=> active == $past(active);
  endproperty
  a_no_commit: assert property (p_no_commit)
    else $error("active settings changed without commit");

  sequence s_small_err;
    ext_en_r && acq_r == ACQ_TRACK && ext_edge && off_mag < TRIM_LIMIT &&
      offset_w != 28'sh0000000;
  endsequence
  property p_trim;
    s_small_err |=> acq_r == ACQ_TRACK && trim_r != $past(trim_r);
  endproperty
  a_trim: assert property (p_trim)
    else $error("small offset not handled by trim alone");

  property p_step;
    ext_en_r && acq_r == ACQ_TRACK && ext_edge && off_mag >= TRIM_LIMIT &&
      persist_r == PERSIST_LAST |=> acq_r == ACQ_JAM;
  endproperty
  a_step: assert property (p_step)
    else $error("persistent large offset not stepped");

  property p_restart;
    $rose(ext_en_r) |=> acq_r == ACQ_JAM;
  endproperty
  a_restart: assert property (p_restart)
    else $error("re-enable did not restart acquisition");

  sequence s_jam;
    jam;
  endsequence
  sequence s_jammed;
    unit_cnt_r == 27'h0000000 && acq_r == ACQ_FINE;
  endsequence
  property p_jam;
    s_jam |=> s_jammed;
  endproperty
  a_jam: assert property (p_jam)
    else $error("jam did not reset counters");

endmodule

// >>> rtl/pulse_out_defines.svh
`ifndef PULSE_OUT_DEFINES_SVH
`define PULSE_OUT_DEFINES_SVH

// ----------------------------------------
// Clock and time units
// ----------------------------------------
`define CLK_MHZ 10
`define CLK_PERIOD_NS 100
`define STEP_NS 10
`define SEC_US 1000000
`define SEC_CYCLES (`SEC_US * `CLK_MHZ)
`define UNITS_PER_CLK (`CLK_PERIOD_NS / `STEP_NS)
`define TRIM_LIMIT_NS 1500
`define TRIM_LIMIT_UNITS (`TRIM_LIMIT_NS / `STEP_NS)
`define PERSIST_SECS 3

// ----------------------------------------
// Pulse widths in microseconds
// ----------------------------------------
`define PW_20US_US 20
`define PW_100US_US 100
`define PW_1MS_US 1000
`define PW_10MS_US 10000
`define PW_100MS_US 100000
`define PW_200MS_US 200000
`define PW_500MS_US 500000
`define PW_CYC(us) (24'((us) * `CLK_MHZ))

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_PEND_PAT 8'h04
`define REG_PEND_WIDTH 8'h08
`define REG_ACT_PAT 8'h0C
`define REG_ACT_WIDTH 8'h10
`define REG_TOD 8'h14
`define REG_STATUS 8'h18
`define REG_TRIM 8'h1C
`define REG_OFFSET 8'h20

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CTRL_EXT_EN_BIT 0
`define CTRL_COMMIT_BIT 1
`define PAT_DIGITS_MSB 23
`define PAT_MASK_LSB 24
`define PAT_MASK_MSB 29
`define WIDTH_MSB 2
`define WIDTH_ONE_SEC 3'h7
`define DEF_DIGITS 24'h000000
`define DEF_MASK 6'h3C
`define DEF_WIDTH 3'h5

`endif

// >>> rtl/pulse_out_pkg.sv
package pulse_out_pkg;

  // ----------------------------------------
  // Pulse settings carried as one word
  // ----------------------------------------
  typedef struct packed {
    logic [5:0] dont_care; // Bit 0 is seconds units
    logic [23:0] digits; // BCD HHMMSS
    logic [2:0] width_sel; // Index into width table
  } settings_s;

  // ----------------------------------------
  // External reference acquisition states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ACQ_OFF,
    ACQ_JAM,
    ACQ_FINE,
    ACQ_TRACK
  } acq_e;

  typedef logic [23:0] bcd_time_t;

endpackage

// >>> rtl/setting_store.sv
`timescale 1ns/1ps
`include "pulse_out_defines.svh"

module setting_store
  import pulse_out_pkg::*;
(
  input wire logic clock_in, // System clock
  input wire logic rst_in, // Synchronous reset
  input wire logic wr_en_in, // Commit strobe
  input wire settings_s wr_data_in, // Settings to retain
  output settings_s rd_data_out, // Retained settings
  output logic saved_out // Save done pulse
);

  // ----------------------------------------
  // Retained word, registered read side
  // ----------------------------------------
  // Store word, defaults until first commit
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rd_data_out <= '{dont_care: `DEF_MASK, digits: `DEF_DIGITS,
                       width_sel: `DEF_WIDTH};
    end else if (wr_en_in) begin
      rd_data_out <= wr_data_in;
    end
  end

  // Save acknowledge
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      saved_out <= 1'b0;
    end else begin
      saved_out <= wr_en_in;
    end
  end

endmodule

// >>> verification/pps_source.sv
`timescale 1ns/1ps

module pps_source #(
  parameter int PERIOD_NS = 100000 // One reference second
)
(
  output logic pps_out // Reference pulse, idle low
);
  // ----------------------------------------
  // Phase control
  // ----------------------------------------
  int pend_ns = 0;
  int gap_ns;

  // Queue a one-off phase jump for the next pulse
  task automatic shift(input int ns);
    pend_ns = pend_ns + ns;
  endtask

  // Free running train, phase unrelated to the clock
  initial begin
    pps_out = 1'b0;
    #12345.6;
    forever begin
      pps_out = 1'b1;
      #(PERIOD_NS / 5);
      pps_out = 1'b0;
      gap_ns = PERIOD_NS - PERIOD_NS / 5 + pend_ns;
      pend_ns = 0;
      #(gap_ns);
    end
  end
endmodule

// >>> verification/programmable_time_pulse_output_test.sv
`timescale 1ns/1ps
`include "pulse_out_defines.svh"

module programmable_time_pulse_output_test;
  // ----------------------------------------
  // Shortened time base and case table
  // ----------------------------------------
  localparam int SEC = 1000;
  localparam logic [7:0][23:0] PW = {24'h3E8, 24'h1F4, 24'hC8, 24'h64,
    24'h32, 24'h14, 24'hA, 24'h4};
  localparam logic [29:0] C_PAT [5] = '{30'h00000010, 30'h00010010,
    30'h01000010, 30'h01000010, 30'h00001234};
  localparam logic [23:0] C_TOD [5] = '{24'h000009, 24'h000009,
    24'h000009, 24'h000014, 24'h001233};
  localparam logic [2:0] C_W [5] = '{3'h2, 3'h2, 3'h1, 3'h1, 3'h3};
  localparam logic C_HIT [5] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h1};

  logic clock_in, rst_in, wr_s, rd_s, ext_pps, pulse, tick, nv, nv_seen;
  logic [7:0] addr;
  logic [31:0] wdata, rd_data, v;
  logic [15:0] trim;
  int bad_count, samples_checked;

  pulse_out_timer #(.SEC_CYCLES(SEC), .PW_CYCLES(PW)) dut (
    .clock_in(clock_in), .rst_in(rst_in), .addr_in(addr),
    .wr_data_in(wdata), .wr_in(wr_s), .rd_in(rd_s),
    .rd_data_out(rd_data), .ext_pps_in(ext_pps), .pulse_out(pulse),
    .sec_tick_out(tick), .freq_trim_out(trim), .nv_save_out(nv));

  pps_source #(.PERIOD_NS(SEC * 100)) src (.pps_out(ext_pps));

  // Clock, 100 ns period
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic fail(input string n);
    $display("Error %s expected done seen timeout", n);
    bad_count++;
    test_done();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clock_in);
    wr_s <= 1'b0;
    #1 nv_seen = nv;
    @(posedge clock_in);
  endtask

  task automatic rd(input logic [7:0] a);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_in);
    rd_s <= 1'b0;
    #1 v = rd_data;
    @(posedge clock_in);
  endtask

  task automatic rdchk(input string n, input logic [7:0] a,
    input logic [31:0] e);
    rd(a);
    chk(n, e, v);
  endtask

  task automatic wait_tick;
    int n;
    #1;
    for (n = 0; n < SEC + 100 && tick !== 1'b1; n++) begin
      @(posedge clock_in);
      #1;
    end
    if (n >= SEC + 100) fail("tick");
  endtask

  // Count pulse high cycles over one second from a tick
  task automatic watch(input int e);
    int c;
    c = 0;
    wait_tick();
    repeat (SEC) begin
      if (pulse === 1'b1) c++;
      @(posedge clock_in);
      #1;
    end
    chk("pulse cycles", 32'(e), 32'(c));
  endtask

  task automatic apply(input logic [29:0] p, input logic [2:0] w);
    wr(`REG_PEND_PAT, {2'h0, p});
    wr(`REG_PEND_WIDTH, {29'h0, w});
    wr(`REG_CTRL, 32'h2);
  endtask

  task automatic wait_acq(input logic [1:0] s);
    int i;
    for (i = 0; i < 80; i++) begin
      rd(`REG_STATUS);
      if (v[1:0] === s) break;
      repeat (100) @(posedge clock_in);
    end
    if (i == 80) fail("acq state");
    chk("acq state", {30'h0, s}, {30'h0, v[1:0]});
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    rst_in = 1'b1;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    nv_seen = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    repeat (6) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    rdchk("active pattern", `REG_ACT_PAT, 32'h3C000000);
    rdchk("active width", `REG_ACT_WIDTH, 32'h5);
    rdchk("status", `REG_STATUS, 32'h0);
    rdchk("unmapped", 8'h40, 32'h0);
    wr(`REG_ACT_WIDTH, 32'h1);
    rdchk("read only width", `REG_ACT_WIDTH, 32'h5);
    $display("test reset done");
    wr(`REG_TOD, 32'h000059);
    watch(PW[5]);
    watch(0);
    wr(`REG_TOD, 32'h235959);
    wait_tick();
    rdchk("day rollover", `REG_TOD, 32'h0);
    $display("test default done");
    wr(`REG_PEND_PAT, 32'h00001234);
    chk("save pulse", 32'h0, {31'h0, nv_seen});
    rdchk("pending pattern", `REG_PEND_PAT, 32'h00001234);
    rdchk("active pattern", `REG_ACT_PAT, 32'h3C000000);
    wr(`REG_CTRL, 32'h2);
    chk("save pulse", 32'h1, {31'h0, nv_seen});
    rdchk("active pattern", `REG_ACT_PAT, 32'h00001234);
    $display("test commit done");
    for (int i = 0; i < 5; i++) begin
      apply(C_PAT[i], C_W[i]);
      wr(`REG_TOD, {8'h0, C_TOD[i]});
      watch(C_HIT[i] ? int'(PW[C_W[i]]) : 0);
    end
    $display("test pattern done");
    for (int w = 0; w < 8; w++) begin
      apply(30'h3F000000, 3'(w));
      wait_tick();
      @(posedge clock_in);
      watch(PW[w]);
    end
    $display("test width done");
    wr(`REG_CTRL, 32'h1);
    rd(`REG_STATUS);
    chk("acq start", 32'h1, {30'h0, v[1:0]});
    wait_acq(2'h3);
    rdchk("offset", `REG_OFFSET, 32'h0);
    src.shift(300);
    repeat (5 * SEC) @(posedge clock_in);
    rd(`REG_STATUS);
    chk("no step", 32'h3, {30'h0, v[1:0]});
    chk("trim moved", 32'h1, {31'h0, trim !== 16'h0});
    src.shift(3000);
    wait_acq(2'h1);
    wait_acq(2'h3);
    rdchk("offset", `REG_OFFSET, 32'h0);
    wr(`REG_CTRL, 32'h0);
    rd(`REG_STATUS);
    chk("acq off", 32'h0, {30'h0, v[1:0]});
    wr(`REG_CTRL, 32'h1);
    rd(`REG_STATUS);
    chk("acq restart", 32'h1, {30'h0, v[1:0]});
    wait_acq(2'h3);
    $display("test reference done");
    test_done();
  end
endmodule
